// [htx_pkg.sv]
// Shared constants, carrier types and pointer helpers for the host transmit path.
package htx_pkg;
    // -----------------------------------------------------------------
    // Register map and field layout
    // -----------------------------------------------------------------
    localparam logic [7:0] HTX_ADDR_TX_DATA = 8'h31;
    localparam logic [7:0] HTX_ADDR_FREE = 8'h32;
    localparam logic [7:0] HTX_ADDR_LEVELS = 8'h34;
    localparam logic [7:0] HTX_ADDR_SHARE = 8'h35;
    localparam int HTX_HOST_LVL_LSB = 0;
    localparam int HTX_PORT_LVL_LSB = 6;
    localparam int HTX_LVL_W = 6;
    localparam int HTX_LEVELS_W = 12;
    localparam int HTX_SHARE_W = 3;
    localparam int HTX_FREE_W = 14;
    localparam int HTX_LEN_W = 11;
    localparam logic [13:0] HTX_FREE_RST = 14'h07ff;
    localparam logic [11:0] HTX_LEVELS_RST = 12'h041;
    localparam logic [2:0] HTX_SHARE_RST = 3'h0;
    localparam logic [2:0] HTX_EQUAL_SHARE = 3'h0;
    localparam logic [2:0] HTX_HOST_FIRST = 3'h5;
    localparam logic [2:0] HTX_PORT_FIRST = 3'h6;

    // -----------------------------------------------------------------
    // FIFO geometry
    // -----------------------------------------------------------------
    localparam int HTX_AW = 10;
    localparam int HTX_PW = 11;
    localparam logic [10:0] HTX_FULL_USED = 11'h3ff;
    localparam logic [10:0] HTX_WORD_BYTES = 11'h004;
    localparam int HTX_CNT_W = 16;

    // -----------------------------------------------------------------
    // Carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } htx_reg_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } htx_fwd_byte_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic sof;
        logic eof;
        logic from_host;
    } htx_tx_byte_t;

    typedef struct packed {
        logic host_ct;
        logic port_ct;
        logic [2:0] share;
        logic [11:0] levels;
    } htx_cfg_t;

    function automatic logic [10:0] htx_bin2gray(input logic [10:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [10:0] htx_gray2bin(input logic [10:0] g);
        logic [10:0] b;
        b[10] = g[10];
        for (int i = 9; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction
endpackage

// [htx_sync.sv]
// Two-flop synchroniser for levels and gray-coded pointers.
`timescale 1ns/10ps
module htx_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } htx_sync_st_t;

    htx_sync_st_t st_reg;
    htx_sync_st_t st_next;

    // The first stage feeds only the second; no reset so nothing else touches it.
    always_comb begin
        st_next.meta = i_d;
        st_next.q = st_reg.meta;
    end

    always_ff @(posedge i_clk) begin
        st_reg <= st_next;
    end

    assign o_q = st_reg.q;
endmodule

// [htx_egress_arb.sv]
// Egress arbiter sharing the port between host frames and forwarded frames.
`timescale 1ns/10ps
module htx_egress_arb import htx_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_share_sel,
    input wire logic i_host_req,
    input wire logic i_port_req,
    input wire logic i_take,
    input wire logic i_host_byte,
    input wire logic i_port_byte,
    output logic o_grant_host,
    output logic o_grant_port
);
    typedef struct packed {
        logic [15:0] host_cnt;
        logic [15:0] port_cnt;
        logic last_host;
    } htx_arb_st_t;

    htx_arb_st_t a_reg;
    htx_arb_st_t a_next;
    logic pick_host;

    always_comb begin
        a_next = a_reg;
        // Recent byte counts; halving both keeps the history short and the ratio intact.
        a_next.host_cnt = a_reg.host_cnt + {15'h0000, i_host_byte};
        a_next.port_cnt = a_reg.port_cnt + {15'h0000, i_port_byte};
        if (a_reg.host_cnt[HTX_CNT_W-1] || a_reg.port_cnt[HTX_CNT_W-1]) begin
            a_next.host_cnt = a_next.host_cnt >> 1;
            a_next.port_cnt = a_next.port_cnt >> 1;
        end
        // Reserved encodings fall back to the equal share.
        case (i_share_sel)
            HTX_HOST_FIRST: pick_host = i_host_req;
            HTX_PORT_FIRST: pick_host = !i_port_req;
            default: begin
                if (!i_host_req || !i_port_req) begin
                    pick_host = i_host_req;
                end else if (a_reg.host_cnt != a_reg.port_cnt) begin
                    pick_host = a_reg.host_cnt < a_reg.port_cnt;
                end else begin
                    pick_host = !a_reg.last_host;
                end
            end
        endcase
        o_grant_host = i_take && i_host_req && pick_host;
        o_grant_port = i_take && i_port_req && !pick_host;
        if (o_grant_host || o_grant_port) begin
            a_next.last_host = o_grant_host;
        end
        if (i_rst) begin
            a_next = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        a_reg <= a_next;
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    a_host_first_wins: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_share_sel == HTX_HOST_FIRST && i_take && i_host_req) |-> o_grant_host && !o_grant_port)
        else $error("host-first setting did not grant the host");
    a_port_first_wins: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_share_sel == HTX_PORT_FIRST && i_take && i_port_req) |-> o_grant_port && !o_grant_host)
        else $error("port-first setting did not grant the port");
    a_equal_fewer_bytes: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_share_sel == HTX_EQUAL_SHARE && i_take && i_host_req && i_port_req
         && a_reg.host_cnt < a_reg.port_cnt) |-> o_grant_host)
        else $error("equal share did not favour the lighter source");
    a_equal_alternates: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_grant_host && i_port_req && i_share_sel == HTX_EQUAL_SHARE
         && a_reg.host_cnt == a_reg.port_cnt) |=> a_reg.last_host)
        else $error("tie break state not recorded");
    c_both_waiting: cover property (@(posedge i_clk) disable iff (i_rst)
        i_take && i_host_req && i_port_req);
endmodule

// [htx_host_tx_fifo.sv]
// Host transmit FIFO with data, free-space, start-level and share registers.
// How it works
// - A data port write in generic mode stores one 32-bit word into the host FIFO.
// - The programmed byte count tells how many bytes of the last word of a frame are real.
// - Free space reads as a 14-bit half-word count that is 0x7ff after reset.
// - With forwarding cut-through on, a forwarded frame starts once its held half words meet the port level.
// - With host cut-through on, a host frame starts once its held half words meet the host level.
// - Both start levels reset to one half word, so the level register reads 0x41.
// - When both sources wait, the 3-bit share select decides who gets the port.
// - In equal share, the decision compares recent byte counts of host and forwarded traffic.
// - Share select 000, the reset value, gives both sources equal shares.
// - Share select 101 always lets the host go first.
// - Share select 110 always lets forwarded traffic go first.
// - Once a frame's byte count is written out, data writes are ignored until the count is set again.
`timescale 1ns/10ps
module htx_host_tx_fifo import htx_pkg::*; (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_link_clk,
    input wire logic i_generic_spi,
    input wire htx_reg_req_t i_reg,
    output logic [31:0] o_reg_rdata,
    input wire logic i_frame_size_wr,
    input wire logic [10:0] i_frame_byte_length,
    input wire logic i_host_cutthrough_on,
    input wire logic i_port_forward_cutthrough_on,
    input wire logic i_fwd_pending,
    input wire logic i_fwd_complete,
    input wire logic [5:0] i_fwd_hw_held,
    input wire htx_fwd_byte_t i_fwd_byte,
    output logic o_fwd_grant,
    output htx_tx_byte_t o_tx
);
    // -----------------------------------------------------------------
    // Types and storage
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {L_IDLE, L_HOST, L_PORT} htx_lstate_t;

    typedef struct packed {
        logic [10:0] wptr;
        logic [10:0] wgray;
        logic [10:0] left;
        logic [11:0] levels;
        logic [2:0] share;
        logic [31:0] rdata;
    } htx_sys_st_t;

    typedef struct packed {
        htx_lstate_t st;
        logic [10:0] rptr;
        logic [10:0] rgray;
        logic have_hdr;
        logic [10:0] len;
        logic [10:0] sent;
        htx_tx_byte_t tx;
        logic fwd_grant;
    } htx_link_st_t;

    logic [31:0] mem [0:(1 << HTX_AW) - 1];

    htx_sys_st_t s_reg;
    htx_sys_st_t s_next;
    htx_link_st_t l_reg;
    htx_link_st_t l_next;

    logic wr_en;
    logic [31:0] wr_data;
    logic [10:0] rgray_s;
    logic [10:0] used_s;
    logic full_s;
    logic [13:0] free_s;
    logic data_wr;

    logic link_rst;
    logic [10:0] wgray_l;
    htx_cfg_t cfg_l;
    htx_cfg_t cfg_s;
    logic [10:0] avail_l;
    logic [10:0] words_l;
    logic [31:0] word_l;
    logic [7:0] byte_l;
    logic frame_in_l;
    logic host_req;
    logic port_req;
    logic grant_host;
    logic grant_port;
    logic last_byte;
    logic take_l;

    // -----------------------------------------------------------------
    // Crossings
    // -----------------------------------------------------------------
    htx_sync #(.W(1)) u_rst_sync (
        .i_clk(i_link_clk),
        .i_d(i_sys_rst),
        .o_q(link_rst)
    );

    htx_sync #(.W(HTX_PW)) u_wptr_sync (
        .i_clk(i_link_clk),
        .i_d(s_reg.wgray),
        .o_q(wgray_l)
    );

    htx_sync #(.W(HTX_PW)) u_rptr_sync (
        .i_clk(i_clk),
        .i_d(l_reg.rgray),
        .o_q(rgray_s)
    );

    // Configuration is quasi-static; a change mid-frame may be seen a few link cycles late.
    assign cfg_s = '{
        host_ct: i_host_cutthrough_on,
        port_ct: i_port_forward_cutthrough_on,
        share: s_reg.share,
        levels: s_reg.levels
    };

    htx_sync #(.W($bits(htx_cfg_t))) u_cfg_sync (
        .i_clk(i_link_clk),
        .i_d(cfg_s),
        .o_q(cfg_l)
    );

    // -----------------------------------------------------------------
    // Write side and registers
    // -----------------------------------------------------------------
    assign used_s = s_reg.wptr - htx_gray2bin(rgray_s);
    assign full_s = used_s >= HTX_FULL_USED;
    assign free_s = HTX_FREE_RST - {2'b00, used_s, 1'b0};
    assign data_wr = i_reg.wr && i_reg.addr == HTX_ADDR_TX_DATA && i_generic_spi;

    always_comb begin
        s_next = s_reg;
        wr_en = 1'b0;
        wr_data = i_reg.wdata;
        // A size write stores the size word that leads the frame in the FIFO.
        if (i_frame_size_wr && !full_s) begin
            wr_en = 1'b1;
            wr_data = {21'h000000, i_frame_byte_length};
            s_next.left = i_frame_byte_length;
        end else if (data_wr && s_reg.left != 11'h000 && !full_s) begin
            wr_en = 1'b1;
            if (s_reg.left > HTX_WORD_BYTES) begin
                s_next.left = s_reg.left - HTX_WORD_BYTES;
            end else begin
                s_next.left = 11'h000;
            end
        end
        if (wr_en) begin
            s_next.wptr = s_reg.wptr + 11'h001;
            s_next.wgray = htx_bin2gray(s_reg.wptr + 11'h001);
        end
        if (i_reg.wr && i_reg.addr == HTX_ADDR_LEVELS) begin
            s_next.levels = i_reg.wdata[HTX_LEVELS_W-1:0];
        end
        if (i_reg.wr && i_reg.addr == HTX_ADDR_SHARE) begin
            s_next.share = i_reg.wdata[HTX_SHARE_W-1:0];
        end
        if (i_reg.rd) begin
            case (i_reg.addr)
                HTX_ADDR_FREE: s_next.rdata = {18'h00000, free_s};
                HTX_ADDR_LEVELS: s_next.rdata = {20'h00000, s_reg.levels};
                HTX_ADDR_SHARE: s_next.rdata = {29'h00000000, s_reg.share};
                default: s_next.rdata = 32'h00000000;
            endcase
        end
        if (i_sys_rst) begin
            s_next = '0;
            s_next.levels = HTX_LEVELS_RST;
            s_next.share = HTX_SHARE_RST;
        end
    end

    always_ff @(posedge i_clk) begin
        s_reg <= s_next;
    end

    always_ff @(posedge i_clk) begin
        if (wr_en && !i_sys_rst) begin
            mem[s_reg.wptr[HTX_AW-1:0]] <= wr_data;
        end
    end

    assign o_reg_rdata = s_reg.rdata;

    // -----------------------------------------------------------------
    // Link side: start levels, arbitration and egress
    // -----------------------------------------------------------------
    assign avail_l = htx_gray2bin(wgray_l) - l_reg.rptr;
    assign words_l = 11'(({1'b0, l_reg.len} + 12'h003) >> 2);
    assign word_l = mem[l_reg.rptr[HTX_AW-1:0]];
    assign frame_in_l = avail_l >= words_l;
    // Store-and-forward waits for the whole frame; cut-through waits for the level or the whole frame, whichever comes first.
    assign host_req = l_reg.have_hdr && (frame_in_l || (cfg_l.host_ct
        && {avail_l, 1'b0} >= {6'h00, cfg_l.levels[HTX_HOST_LVL_LSB +: HTX_LVL_W]}));
    assign port_req = i_fwd_pending && (i_fwd_complete || (cfg_l.port_ct
        && i_fwd_hw_held >= cfg_l.levels[HTX_PORT_LVL_LSB +: HTX_LVL_W]));
    assign last_byte = l_reg.sent + 11'h001 >= l_reg.len;
    // An unread size word is loaded before arbitration; otherwise a complete host frame
    // would lose the idle cycle to forwarded traffic whatever the share select says.
    assign take_l = l_reg.st == L_IDLE && (l_reg.have_hdr || avail_l == 11'h000);

    always_comb begin
        case (l_reg.sent[1:0])
            2'h0: byte_l = word_l[31:24];
            2'h1: byte_l = word_l[23:16];
            2'h2: byte_l = word_l[15:8];
            default: byte_l = word_l[7:0];
        endcase
    end

    htx_egress_arb u_arb (
        .i_clk(i_link_clk),
        .i_rst(link_rst),
        .i_share_sel(cfg_l.share),
        .i_host_req(host_req),
        .i_port_req(port_req),
        .i_take(take_l),
        .i_host_byte(l_reg.tx.valid && l_reg.tx.from_host),
        .i_port_byte(l_reg.tx.valid && !l_reg.tx.from_host),
        .o_grant_host(grant_host),
        .o_grant_port(grant_port)
    );

    always_comb begin
        l_next = l_reg;
        l_next.tx = '0;
        case (l_reg.st)
            L_IDLE: begin
                if (grant_host) begin
                    l_next.st = L_HOST;
                end else if (grant_port) begin
                    l_next.st = L_PORT;
                    l_next.fwd_grant = 1'b1;
                end else if (!l_reg.have_hdr && avail_l != 11'h000) begin
                    l_next.len = word_l[HTX_LEN_W-1:0];
                    l_next.have_hdr = word_l[HTX_LEN_W-1:0] != 11'h000;
                    l_next.rptr = l_reg.rptr + 11'h001;
                end
            end
            L_HOST: begin
                // A cut-through frame can outrun the writer; the link then idles a byte.
                if (avail_l != 11'h000) begin
                    l_next.tx.valid = 1'b1;
                    l_next.tx.data = byte_l;
                    l_next.tx.sof = l_reg.sent == 11'h000;
                    l_next.tx.eof = last_byte;
                    l_next.tx.from_host = 1'b1;
                    l_next.sent = l_reg.sent + 11'h001;
                    if (l_reg.sent[1:0] == 2'h3 || last_byte) begin
                        l_next.rptr = l_reg.rptr + 11'h001;
                    end
                    if (last_byte) begin
                        l_next.st = L_IDLE;
                        l_next.have_hdr = 1'b0;
                        l_next.sent = 11'h000;
                    end
                end
            end
            L_PORT: begin
                l_next.tx.valid = i_fwd_byte.valid;
                l_next.tx.data = i_fwd_byte.data;
                l_next.tx.sof = i_fwd_byte.valid && l_reg.sent == 11'h000;
                l_next.tx.eof = i_fwd_byte.valid && i_fwd_byte.last;
                if (i_fwd_byte.valid) begin
                    l_next.sent = l_reg.sent + 11'h001;
                    if (i_fwd_byte.last) begin
                        l_next.st = L_IDLE;
                        l_next.fwd_grant = 1'b0;
                        l_next.sent = 11'h000;
                    end
                end
            end
            default: begin
                l_next.st = L_IDLE;
            end
        endcase
        l_next.rgray = htx_bin2gray(l_next.rptr);
        if (link_rst) begin
            l_next = '0;
            l_next.st = L_IDLE;
        end
    end

    always_ff @(posedge i_link_clk) begin
        l_reg <= l_next;
    end

    assign o_fwd_grant = l_reg.fwd_grant;
    assign o_tx = l_reg.tx;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    a_word_appended: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (data_wr && !i_frame_size_wr && s_reg.left != 11'h000 && !full_s)
        |=> s_reg.wptr == $past(s_reg.wptr) + 11'h001)
        else $error("data port write not appended");
    a_extra_ignored: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (data_wr && !i_frame_size_wr && s_reg.left == 11'h000) |=> $stable(s_reg.wptr))
        else $error("write past frame end was stored");
    a_last_word_ends: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (data_wr && !i_frame_size_wr && !full_s && s_reg.left != 11'h000
         && s_reg.left <= HTX_WORD_BYTES)
        |=> s_reg.left == 11'h000 && (!wr_en || i_frame_size_wr))
        else $error("partial last word did not close the frame");
    a_free_when_empty: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (used_s == 11'h000) |-> free_s == HTX_FREE_RST)
        else $error("free space wrong on empty FIFO");
    a_free_falls_two: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (wr_en ##1 $stable(rgray_s)) |-> free_s == $past(free_s) - 14'h0002)
        else $error("free space did not drop by one word");
    a_levels_reset: assert property (@(posedge i_clk)
        $past(i_sys_rst) |-> s_reg.levels == HTX_LEVELS_RST && s_reg.share == HTX_SHARE_RST)
        else $error("start levels not at reset value");
    a_host_start_level: assert property (@(posedge i_link_clk) disable iff (link_rst)
        (l_reg.st == L_IDLE && grant_host) |-> frame_in_l || (cfg_l.host_ct
         && {avail_l, 1'b0} >= {6'h00, cfg_l.levels[HTX_HOST_LVL_LSB +: HTX_LVL_W]}))
        else $error("host frame started below its start level");
    a_port_start_level: assert property (@(posedge i_link_clk) disable iff (link_rst)
        (l_reg.st == L_IDLE && grant_port) |=> o_fwd_grant && ($past(i_fwd_complete)
         || ($past(cfg_l.port_ct) && $past(i_fwd_hw_held)
         >= $past(cfg_l.levels[HTX_PORT_LVL_LSB +: HTX_LVL_W]))))
        else $error("forwarded frame started below its start level");
    a_free_rises: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!wr_en ##1 $changed(rgray_s)) |-> free_s > $past(free_s))
        else $error("free space did not rise as words drained");
    a_size_word_first: assert property (@(posedge i_link_clk) disable iff (link_rst)
        (l_reg.st == L_IDLE && !l_reg.have_hdr && avail_l != 11'h000) |=> l_reg.st == L_IDLE)
        else $error("frame granted before the waiting size word was read");
    a_host_excludes_port: assert property (@(posedge i_link_clk) disable iff (link_rst)
        (o_tx.valid && o_tx.from_host) |-> !o_fwd_grant)
        else $error("host byte sent while the port owned egress");
    a_port_bytes_pass: assert property (@(posedge i_link_clk) disable iff (link_rst)
        (l_reg.st == L_PORT && i_fwd_byte.valid) |=> o_tx.valid && !o_tx.from_host
         && o_tx.data == $past(i_fwd_byte.data))
        else $error("forwarded byte not passed to egress");
    c_frame_filled: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        i_frame_size_wr ##[1:40] (data_wr && s_reg.left != 11'h000 && s_reg.left <= 11'h003));
    c_host_frame_sent: cover property (@(posedge i_link_clk) disable iff (link_rst)
        o_tx.valid && o_tx.from_host && o_tx.eof);
    c_port_frame_sent: cover property (@(posedge i_link_clk) disable iff (link_rst)
        o_tx.valid && !o_tx.from_host && o_tx.eof);
endmodule

// [htx_host_model.sv]
// Host-side register master that writes frames into the transmit FIFO.
`timescale 1ns/10ps
module htx_host_model import htx_pkg::*; (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    output htx_reg_req_t o_reg,
    output logic o_size_wr,
    output logic [10:0] o_len
);
    initial begin
        o_reg = '0;
        o_size_wr = 1'b0;
        o_len = 11'h000;
    end
    // One pulse per access; read data is taken one edge after the request edge.
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        @(negedge i_clk);
        o_reg = '{wr: w, rd: ~w, addr: a, wdata: d};
        @(negedge i_clk);
        o_reg = '0;
        @(posedge i_clk);
        #1 q = i_rdata;
    endtask
    task automatic frame(input logic [10:0] n, input int words, input logic [7:0] seed);
        logic [7:0] b;
        @(negedge i_clk);
        o_size_wr = 1'b1;
        o_len = n;
        for (int i = 0; i < words; i++) begin
            b = seed + 8'(4 * i);
            @(negedge i_clk);
            o_size_wr = 1'b0;
            o_reg = '{wr: 1'b1, rd: 1'b0, addr: HTX_ADDR_TX_DATA,
                      wdata: {b, b + 8'h01, b + 8'h02, b + 8'h03}};
        end
        @(negedge i_clk);
        o_size_wr = 1'b0;
        o_reg = '0;
    endtask
endmodule

// [htx_host_tx_fifo_tb.sv]
// Self-checking bench for the host transmit FIFO and egress arbiter.
`timescale 1ns/10ps
module htx_host_tx_fifo_tb;
    import htx_pkg::*;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst = 1'b1;
    logic fwd_pend = 1'b0;
    logic ct = 1'b0;
    logic fwd_grant;
    logic size_wr;
    logic [31:0] rdata;
    logic [31:0] q;
    logic [10:0] len;
    htx_reg_req_t req;
    htx_fwd_byte_t fwd_b = '0;
    htx_tx_byte_t tx;
    logic [10:0] txq[$];
    int error_cnt = 0;
    int comparisons = 0;
    int fcnt = 0;
    always #20 clk = ~clk;
    initial begin
        #7;
        forever #16 lclk = ~lclk;
    end
    htx_host_tx_fifo u_dut (.i_clk(clk), .i_sys_rst(rst), .i_link_clk(lclk), .i_generic_spi(1'b1),
        .i_reg(req), .o_reg_rdata(rdata), .i_frame_size_wr(size_wr), .i_frame_byte_length(len),
        .i_host_cutthrough_on(ct), .i_port_forward_cutthrough_on(1'b0),
        .i_fwd_pending(fwd_pend), .i_fwd_complete(fwd_pend), .i_fwd_hw_held(6'h00),
        .i_fwd_byte(fwd_b), .o_fwd_grant(fwd_grant), .o_tx(tx));
    htx_host_model u_host (.i_clk(clk), .i_rdata(rdata), .o_reg(req), .o_size_wr(size_wr),
        .o_len(len));
    // -----------------------------------------------------------------
    // Link side: capture every egress byte, feed one forwarded frame of four
    // -----------------------------------------------------------------
    always @(negedge lclk) if (tx.valid) txq.push_back({tx.from_host, tx.sof, tx.eof, tx.data});
    always @(negedge lclk) begin
        fwd_b.valid = fwd_grant && fcnt < 4;
        fwd_b.data = 8'hf0 + 8'(fcnt);
        fwd_b.last = fcnt == 3;
        if (fwd_b.valid) fcnt++;
        if (fcnt == 4) fwd_pend = 1'b0;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic drain(input int n);
        for (int i = 0; i < 3000 && txq.size() < n; i++) @(posedge clk);
    endtask
    // Forwarded bytes are judged on source and data only; their framing flags are not ours.
    task automatic check_frame(input logic host, input logic [7:0] seed, input int n);
        logic [10:0] m;
        m = host ? 11'h7ff : 11'h4ff;
        for (int k = 0; k < n; k++) begin
            check("tx byte", 32'(txq.pop_front() & m),
                  32'({host, k == 0, k == n - 1, seed + 8'(k)} & m));
        end
    endtask
    task automatic t_reset;
        u_host.access(1'b0, HTX_ADDR_FREE, 32'h0, q);
        check("free", q, 32'h0000_07ff);
        u_host.access(1'b0, HTX_ADDR_LEVELS, 32'h0, q);
        check("levels", q, 32'h0000_0041);
        u_host.access(1'b0, HTX_ADDR_SHARE, 32'h0, q);
        check("share", q, 32'h0);
        u_host.access(1'b0, 8'h33, 32'h0, q);
        check("unmapped", q, 32'h0);
        u_host.access(1'b1, HTX_ADDR_LEVELS, 32'hfff0_0683, q);
        u_host.access(1'b0, HTX_ADDR_LEVELS, 32'h0, q);
        check("levels", q, 32'h0000_0683);
        $display("test registers done");
    endtask
    task automatic t_frame;
        u_host.access(1'b0, HTX_ADDR_FREE, 32'h0, q);
        check("room", 32'((q - 32'h2) * 32'h2 >= 32'h5), 32'h1);
        u_host.frame(11'h005, 3, 8'h20);
        drain(5);
        check_frame(1'b1, 8'h20, 5);
        repeat (20) @(posedge clk);
        u_host.access(1'b0, HTX_ADDR_FREE, 32'h0, q);
        check("free", q, 32'h0000_07ff);
        check("extra", 32'(txq.size()), 32'h0);
        $display("test frame done");
    endtask
    // Under cut-through the first byte must leave before the writer has finished the frame.
    task automatic t_cut;
        @(negedge clk);
        ct = 1'b1;
        repeat (4) @(posedge clk);
        u_host.frame(11'h028, 10, 8'hc0);
        check("early start", 32'(txq.size() != 0), 32'h1);
        drain(40);
        check_frame(1'b1, 8'hc0, 40);
        @(negedge clk);
        ct = 1'b0;
        $display("test cut-through done");
    endtask
    task automatic t_share(input logic [2:0] sel, input logic hw);
        u_host.access(1'b1, HTX_ADDR_SHARE, 32'(sel), q);
        u_host.frame(11'h028, 10, 8'h40);
        repeat (10) @(posedge clk);
        @(posedge lclk);
        #4;
        fcnt = 0;
        fwd_pend = 1'b1;
        u_host.frame(11'h006, 2, 8'h80);
        drain(50);
        check_frame(1'b1, 8'h40, 40);
        check_frame(hw, hw ? 8'h80 : 8'hf0, hw ? 6 : 4);
        check_frame(!hw, hw ? 8'hf0 : 8'h80, hw ? 4 : 6);
        $display("test share %b done", sel);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (10) @(posedge clk);
        t_reset;
        t_frame;
        t_cut;
        t_share(3'h0, 1'b0);
        t_share(3'h5, 1'b1);
        t_share(3'h6, 1'b0);
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop;
    end
endmodule
